// [verif/tpioc_ch4_pin_io_tb.sv]
`timescale 1ns/100ps
module tpioc_ch4_pin_io_tb
  import tpioc_pkg::*;
();
  logic core_clk = 0, rst = 1, clk_en = 1, wr_stb = 0, rd_stb = 0, cnt_inc = 0, irq, lvl, hit;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic [2:0] pin, drv, oe, ext = 3'h0;
  int num_errors = 0, num_checks = 0;
  always #2 core_clk = ~core_clk;
  tpioc_ch4_pin_io DUT (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cnt_inc(cnt_inc), .timer_pin_a_ch4_in(pin[0]),
    .timer_pin_c_ch4_in(pin[1]), .timer_pin_d_ch4_in(pin[2]), .timer_pin_a_ch4_out(drv[0]),
    .timer_pin_c_ch4_out(drv[1]), .timer_pin_d_ch4_out(drv[2]), .timer_pin_a_ch4_oe(oe[0]),
    .timer_pin_c_ch4_oe(oe[1]), .timer_pin_d_ch4_oe(oe[2]), .irq(irq));
  tpioc_pin_model PM (.oe(oe), .drv(drv), .ext(ext), .pin(pin));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1;
    @(posedge core_clk);
    wr_stb <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk);
    addr <= a;
    rd_stb <= 1;
    @(posedge core_clk);
    rd_stb <= 0;
    #1 chk(rdata, e);
  endtask
  task summarize;
    if (num_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #40000;
    num_errors++;
    summarize;
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    #1 chk(16'({oe, drv, irq}), 16'h0070);
    for (int a = 0; a < 3; a++) rd(4'(a), 16'h0000);
    rd(4'hF, 16'h0000);
    wr(ADDR_MASK, 16'h0001);
    wr(ADDR_GRA, 16'h0002);
    wr(ADDR_COUNT, 16'h0004);
    wr(ADDR_STATUS, 16'h0007);
    lvl = 0;
    for (int k = 0; k < 8; k++) begin
      wr(ADDR_IOR_HIGH, 16'(k));
      if (k[1:0] != 2'h0) lvl = k[2];
      #1 chk(16'(drv[0]), 16'(lvl));
      wr(ADDR_COUNT, 16'h0000);
      cnt_inc <= 1;
      repeat (4) @(posedge core_clk);
      cnt_inc <= 0;
      case (k[1:0])
        2'h1: lvl = 0;
        2'h2: lvl = 1;
        2'h3: lvl = ~lvl;
        default: ;
      endcase
      #1 chk(16'({irq, drv[0]}), 16'({1'b1, lvl}));
      rd(ADDR_STATUS, 16'h0007);
      wr(ADDR_STATUS, 16'h0007);
    end
    clk_en <= 0;
    repeat (3) @(posedge core_clk);
    clk_en <= 1;
    wr(ADDR_MASK, 16'h0000);
    for (int k = 8; k < 16; k++) begin
      wr(ADDR_IOR_HIGH, 16'(k));
      wr(ADDR_COUNT, 16'(k));
      for (int e = 0; e < 2; e++) begin
        repeat (4) @(posedge core_clk);
        wr(ADDR_GRA, 16'h0000);
        wr(ADDR_STATUS, 16'h0007);
        ext[0] <= (e == 0);
        repeat (5) @(posedge core_clk);
        hit = (e == 0) ? (k[1] | !k[0]) : (k[1] | k[0]);
        rd(ADDR_GRA, hit ? 16'(k) : 16'h0000);
      end
    end
    chk(16'(irq), 16'h0000);
    wr(ADDR_MASK, 16'h0001);
    @(posedge core_clk);
    #1 chk(16'(irq), 16'h0001);
    wr(ADDR_IOR_LOW, 16'h0075);
    #1 chk(16'(drv[2:1]), 16'h0003);
    wr(ADDR_IOR_LOW, 16'h0088);
    for (int m = 1; m < 3; m++) begin
      wr(ADDR_MODE, 16'(m << 4));
      repeat (4) @(posedge core_clk);
      wr(ADDR_STATUS, 16'h0007);
      ext[2:1] <= 2'h3;
      repeat (5) @(posedge core_clk);
      rd(ADDR_STATUS, (m == 1) ? 16'h0004 : 16'h0002);
      ext[2:1] <= 2'h0;
    end
    summarize;
  end
endmodule

// [verif/tpioc_ch4_props.sv]
`timescale 1ns/100ps
module tpioc_ch4_props
  import tpioc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [15:0] rdata,
  input wire logic timer_pin_a_ch4_out,
  input wire logic timer_pin_a_ch4_oe,
  input wire logic timer_pin_c_ch4_out,
  input wire logic timer_pin_d_ch4_out,
  input wire logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic wa;
  logic wl;
  assign wa = clk_en && wr_stb && addr == ADDR_IOR_HIGH;
  assign wl = clk_en && wr_stb && addr == ADDR_IOR_LOW;
  property p_rst;
    $fell(rst) |-> !timer_pin_a_ch4_out && timer_pin_a_ch4_oe && !irq;
  endproperty
  a_rst: assert property (p_rst) else $error("pin not low after reset");
  property p_cap;
    wa && wdata[3] |=> !timer_pin_a_ch4_oe && !timer_pin_a_ch4_out;
  endproperty
  a_cap: assert property (p_cap) else $error("capture field still drives pin");
  property p_cmp;
    wa && !wdata[3] |=> timer_pin_a_ch4_oe;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare field not driving pin");
  property p_ia;
    wa && !wdata[3] && wdata[1:0] != 2'h0 |=> timer_pin_a_ch4_out == $past(wdata[2]);
  endproperty
  a_ia: assert property (p_ia) else $error("pin a initial level wrong");
  property p_ic;
    wl && !wdata[3] && wdata[1:0] != 2'h0 |=> timer_pin_c_ch4_out == $past(wdata[2]);
  endproperty
  a_ic: assert property (p_ic) else $error("pin c initial level wrong");
  property p_id;
    wl && !wdata[7] && wdata[5:4] != 2'h0 |=> timer_pin_d_ch4_out == $past(wdata[6]);
  endproperty
  a_id: assert property (p_id) else $error("pin d initial level wrong");
  property p_hold;
    wa && !wdata[3] && wdata[1:0] == 2'h0 |=> $stable(timer_pin_a_ch4_out);
  endproperty
  a_hold: assert property (p_hold) else $error("hold code changed pin");
  property p_frz;
    !clk_en |=> $stable(timer_pin_a_ch4_out) && $stable(irq) && $stable(rdata);
  endproperty
  a_frz: assert property (p_frz) else $error("state moved while frozen");
  property p_rd;
    clk_en && !rd_stb |=> rdata == 16'h0000;
  endproperty
  a_rd: assert property (p_rd) else $error("read data outside read slot");
  c_cap: cover property (wa && wdata[3]);
  c_irq: cover property ($rose(irq));
  c_frz: cover property (!clk_en);
endmodule
bind tpioc_ch4_pin_io tpioc_ch4_props CHK (.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .addr(addr),
  .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .timer_pin_a_ch4_out(timer_pin_a_ch4_out),
  .timer_pin_a_ch4_oe(timer_pin_a_ch4_oe), .timer_pin_c_ch4_out(timer_pin_c_ch4_out),
  .timer_pin_d_ch4_out(timer_pin_d_ch4_out), .irq(irq));

// [verif/tpioc_pin_model.sv]
`timescale 1ns/100ps
module tpioc_pin_model (
  input wire logic [2:0] oe,
  input wire logic [2:0] drv,
  input wire logic [2:0] ext,
  output logic [2:0] pin
);
  // device drives where enabled, far side elsewhere
  assign pin = (oe & drv) | (~oe & ext);
endmodule

// [verilog/tpioc_ch4_pin_io.sv]
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module tpioc_ch4_pin_io
  import tpioc_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  input wire logic cnt_inc,
  input wire logic timer_pin_a_ch4_in,
  input wire logic timer_pin_c_ch4_in,
  input wire logic timer_pin_d_ch4_in,
  output logic timer_pin_a_ch4_out,
  output logic timer_pin_c_ch4_out,
  output logic timer_pin_d_ch4_out,
  output logic timer_pin_a_ch4_oe,
  output logic timer_pin_c_ch4_oe,
  output logic timer_pin_d_ch4_oe,
  output logic irq
);

  logic [7:0] io_control_high_ch4_reg;
  logic [7:0] io_control_low_ch4_reg;
  logic [7:0] timer_mode_reg_ch4_reg;
  logic [2:0] status_reg;
  logic [2:0] mask_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] gr_reg [3];
  logic [CW-1:0] general_reg_a_ch4_reg;
  logic [CW-1:0] general_reg_c_ch4_reg;
  logic [CW-1:0] general_reg_d_ch4_reg;
  logic flag_a_reg;
  logic flag_c_reg;
  logic flag_d_reg;
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic [2:0] pin_s3_reg;
  logic pin_a_out_reg;
  logic pin_c_out_reg;
  logic pin_d_out_reg;
  logic pin_a_oe_reg;
  logic pin_c_oe_reg;
  logic pin_d_oe_reg;
  logic [15:0] rdata_reg;
  logic irq_reg;
  logic [FIELD_W-1:0] field [3];
  logic [FIELD_W-1:0] field_nx [3];
  logic [2:0] active;
  logic [2:0] cap_hit;
  logic [2:0] cmp_hit;
  logic [2:0] field_wr;
  logic [2:0] pin_now;
  logic wr_high;
  logic wr_low;

  function automatic logic edge_sel(input logic [FIELD_W-1:0] f, input logic rise, input logic fall);
    if (f[1]) begin
      edge_sel = rise | fall;
    end else if (f[1:0] == EDGE_FALL) begin
      edge_sel = fall;
    end else begin
      edge_sel = rise;
    end
  endfunction

  function automatic logic cmp_level(input logic [FIELD_W-1:0] f, input logic cur);
    unique case (f[1:0])
      ACT_LOW: cmp_level = 1'b0;
      ACT_HIGH: cmp_level = 1'b1;
      ACT_TOGGLE: cmp_level = ~cur;
      default: cmp_level = cur;
    endcase
  endfunction

  function automatic logic wr_sel(input logic stb, input logic [3:0] a, input logic [3:0] target);
    wr_sel = stb && (a == target);
  endfunction

  // compare code that carries an initial level
  function automatic logic init_valid(input logic [FIELD_W-1:0] f);
    init_valid = !f[CAP_BIT] && (f[1:0] != ACT_HOLD);
  endfunction

  assign wr_high = clk_en & wr_stb & (addr == ADDR_IOR_HIGH);
  assign wr_low = clk_en & wr_stb & (addr == ADDR_IOR_LOW);
  assign field[IDX_A] = io_control_high_ch4_reg[FA_LSB +: FIELD_W];
  assign field[IDX_C] = io_control_low_ch4_reg[FC_LSB +: FIELD_W];
  assign field[IDX_D] = io_control_low_ch4_reg[FD_LSB +: FIELD_W];
  assign field_wr = {wr_low, wr_low, wr_high};
  assign pin_now = pin_s2_reg;
  assign gr_reg[IDX_A] = general_reg_a_ch4_reg;
  assign gr_reg[IDX_C] = general_reg_c_ch4_reg;
  assign gr_reg[IDX_D] = general_reg_d_ch4_reg;
  assign status_reg = {flag_d_reg, flag_c_reg, flag_a_reg};

  // field as it stands after this edge, so a written code acts at once
  assign field_nx[IDX_A] = wr_high ? wdata[FA_LSB +: FIELD_W] : field[IDX_A];
  assign field_nx[IDX_C] = wr_low ? wdata[FC_LSB +: FIELD_W] : field[IDX_C];
  assign field_nx[IDX_D] = wr_low ? wdata[FD_LSB +: FIELD_W] : field[IDX_D];

  // buffer use stops capture and compare on the secondary register; field writes still set its pin and enable
  assign active[IDX_A] = 1'b1;
  assign active[IDX_C] = ~timer_mode_reg_ch4_reg[BFA_BIT];
  assign active[IDX_D] = ~timer_mode_reg_ch4_reg[BFB_BIT];

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      cap_hit[i] = active[i] & field[i][CAP_BIT] &
                   edge_sel(field[i], pin_now[i] & ~pin_s3_reg[i], ~pin_now[i] & pin_s3_reg[i]);
      cmp_hit[i] = active[i] & ~field[i][CAP_BIT] & clk_en & (count_reg == gr_reg[i]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
      pin_s3_reg <= 3'h0;
    end else if (clk_en) begin
      pin_s1_reg <= {timer_pin_d_ch4_in, timer_pin_c_ch4_in, timer_pin_a_ch4_in};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      io_control_high_ch4_reg <= IOR_RESET;
    end else if (clk_en && wr_sel(wr_stb, addr, ADDR_IOR_HIGH)) begin
      io_control_high_ch4_reg <= wdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      io_control_low_ch4_reg <= IOR_RESET;
    end else if (clk_en && wr_sel(wr_stb, addr, ADDR_IOR_LOW)) begin
      io_control_low_ch4_reg <= wdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      timer_mode_reg_ch4_reg <= IOR_RESET;
    end else if (clk_en && wr_sel(wr_stb, addr, ADDR_MODE)) begin
      timer_mode_reg_ch4_reg <= wdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask_reg <= FLAG_RESET;
    end else if (clk_en && wr_sel(wr_stb, addr, ADDR_MASK)) begin
      mask_reg <= wdata[2:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_reg <= '0;
    end else if (clk_en) begin
      if (wr_stb && addr == ADDR_COUNT) begin
        count_reg <= wdata[CW-1:0];
      end else if (cnt_inc) begin
        count_reg <= count_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      general_reg_a_ch4_reg <= '0;
    end else if (clk_en) begin
      if (cap_hit[IDX_A]) begin
        general_reg_a_ch4_reg <= count_reg;
      end else if (wr_sel(wr_stb, addr, ADDR_GRA)) begin
        general_reg_a_ch4_reg <= wdata[CW-1:0];
      end
    end
  end

  // capture wins over a software write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      general_reg_c_ch4_reg <= '0;
    end else if (clk_en) begin
      if (cap_hit[IDX_C]) begin
        general_reg_c_ch4_reg <= count_reg;
      end else if (wr_sel(wr_stb, addr, ADDR_GRC)) begin
        general_reg_c_ch4_reg <= wdata[CW-1:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      general_reg_d_ch4_reg <= '0;
    end else if (clk_en) begin
      if (cap_hit[IDX_D]) begin
        general_reg_d_ch4_reg <= count_reg;
      end else if (wr_sel(wr_stb, addr, ADDR_GRD)) begin
        general_reg_d_ch4_reg <= wdata[CW-1:0];
      end
    end
  end

  // set beats a write-one clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_a_reg <= FLAG_RESET[IDX_A];
    end else if (clk_en) begin
      if (cap_hit[IDX_A] || cmp_hit[IDX_A]) begin
        flag_a_reg <= 1'b1;
      end else if (wr_sel(wr_stb, addr, ADDR_STATUS) && wdata[IDX_A]) begin
        flag_a_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_c_reg <= FLAG_RESET[IDX_C];
    end else if (clk_en) begin
      if (cap_hit[IDX_C] || cmp_hit[IDX_C]) begin
        flag_c_reg <= 1'b1;
      end else if (wr_sel(wr_stb, addr, ADDR_STATUS) && wdata[IDX_C]) begin
        flag_c_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      flag_d_reg <= FLAG_RESET[IDX_D];
    end else if (clk_en) begin
      if (cap_hit[IDX_D] || cmp_hit[IDX_D]) begin
        flag_d_reg <= 1'b1;
      end else if (wr_sel(wr_stb, addr, ADDR_STATUS) && wdata[IDX_D]) begin
        flag_d_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_a_out_reg <= 1'b0;
      pin_a_oe_reg <= 1'b1;
    end else if (clk_en) begin
      pin_a_oe_reg <= ~field_nx[IDX_A][CAP_BIT];
      if (field_nx[IDX_A][CAP_BIT]) begin
        pin_a_out_reg <= 1'b0;
      end else if (field_wr[IDX_A]) begin
        if (init_valid(field_nx[IDX_A])) begin
          pin_a_out_reg <= field_nx[IDX_A][INIT_BIT];
        end
      end else if (cmp_hit[IDX_A]) begin
        pin_a_out_reg <= cmp_level(field_nx[IDX_A], pin_a_out_reg);
      end
    end
  end

  // a field write takes precedence over a match in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_c_out_reg <= 1'b0;
      pin_c_oe_reg <= 1'b1;
    end else if (clk_en) begin
      pin_c_oe_reg <= ~field_nx[IDX_C][CAP_BIT];
      if (field_nx[IDX_C][CAP_BIT]) begin
        pin_c_out_reg <= 1'b0;
      end else if (field_wr[IDX_C]) begin
        if (init_valid(field_nx[IDX_C])) begin
          pin_c_out_reg <= field_nx[IDX_C][INIT_BIT];
        end
      end else if (cmp_hit[IDX_C]) begin
        pin_c_out_reg <= cmp_level(field_nx[IDX_C], pin_c_out_reg);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_d_out_reg <= 1'b0;
      pin_d_oe_reg <= 1'b1;
    end else if (clk_en) begin
      pin_d_oe_reg <= ~field_nx[IDX_D][CAP_BIT];
      if (field_nx[IDX_D][CAP_BIT]) begin
        pin_d_out_reg <= 1'b0;
      end else if (field_wr[IDX_D]) begin
        if (init_valid(field_nx[IDX_D])) begin
          pin_d_out_reg <= field_nx[IDX_D][INIT_BIT];
        end
      end else if (cmp_hit[IDX_D]) begin
        pin_d_out_reg <= cmp_level(field_nx[IDX_D], pin_d_out_reg);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg <= 16'h0000;
    end else if (clk_en) begin
      rdata_reg <= 16'h0000;
      if (rd_stb) begin
        unique case (addr)
          ADDR_IOR_HIGH: rdata_reg <= {8'h00, io_control_high_ch4_reg};
          ADDR_IOR_LOW: rdata_reg <= {8'h00, io_control_low_ch4_reg};
          ADDR_MODE: rdata_reg <= {8'h00, timer_mode_reg_ch4_reg};
          ADDR_STATUS: rdata_reg <= {13'h0000, status_reg};
          ADDR_MASK: rdata_reg <= {13'h0000, mask_reg};
          ADDR_GRA: rdata_reg <= 16'(gr_reg[IDX_A]);
          ADDR_GRC: rdata_reg <= 16'(gr_reg[IDX_C]);
          ADDR_GRD: rdata_reg <= 16'(gr_reg[IDX_D]);
          ADDR_COUNT: rdata_reg <= 16'(count_reg);
          default: rdata_reg <= 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else if (clk_en) begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  assign rdata = rdata_reg;
  assign irq = irq_reg;
  assign timer_pin_a_ch4_out = pin_a_out_reg;
  assign timer_pin_c_ch4_out = pin_c_out_reg;
  assign timer_pin_d_ch4_out = pin_d_out_reg;
  assign timer_pin_a_ch4_oe = pin_a_oe_reg;
  assign timer_pin_c_ch4_oe = pin_c_oe_reg;
  assign timer_pin_d_ch4_oe = pin_d_oe_reg;

endmodule

// [verilog/tpioc_pkg.sv]
package tpioc_pkg;
  localparam int CNT_W = 16;
  localparam int FIELD_W = 4;
  // register indices on the plain port
  localparam logic [3:0] ADDR_IOR_HIGH = 4'h0;
  localparam logic [3:0] ADDR_IOR_LOW = 4'h1;
  localparam logic [3:0] ADDR_MODE = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_MASK = 4'h4;
  localparam logic [3:0] ADDR_GRA = 4'h5;
  localparam logic [3:0] ADDR_GRC = 4'h6;
  localparam logic [3:0] ADDR_GRD = 4'h7;
  localparam logic [3:0] ADDR_COUNT = 4'h8;
  // field positions
  localparam int FA_LSB = 0;
  localparam int FD_LSB = 4;
  localparam int FC_LSB = 0;
  localparam int BFA_BIT = 4;
  localparam int BFB_BIT = 5;
  localparam int CAP_BIT = 3;
  localparam int INIT_BIT = 2;
  localparam logic [7:0] IOR_RESET = 8'h00;
  localparam logic [2:0] FLAG_RESET = 3'h0;
  // low two bits of a field
  localparam logic [1:0] ACT_HOLD = 2'h0;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOGGLE = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  // flag positions: A, C, D
  localparam int IDX_A = 0;
  localparam int IDX_C = 1;
  localparam int IDX_D = 2;
endpackage
